/* src/line_xfer_pkg.sv */
// Constants, register map and state types for the line mode transfer block.
// Assumes volts are whole-volt unsigned bytes and a 100 MHz core clock.
package line_xfer_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SECOND_NS       = 1_000_000_000;
  localparam int unsigned CYCLES_PER_SEC  = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  QUAL_3_SEC      = 5'h03;
  localparam logic [4:0]  QUAL_10_SEC     = 5'h0A;
  localparam logic [4:0]  QUAL_30_SEC     = 5'h1E;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_KEY     = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_UPPER   = 8'h0C;
  localparam logic [7:0] OFS_LOWER   = 8'h10;
  localparam logic [7:0] OFS_GAPS    = 8'h14;
  localparam logic [7:0] OFS_VIN     = 8'h18;

  // Control field positions and reset values
  localparam int         CTRL_BUCK_BIT   = 0;
  localparam int         CTRL_BOOST_BIT  = 1;
  localparam int         CTRL_QUAL_LSB   = 2;
  localparam logic [1:0] QUAL_SEL_3      = 2'h0;
  localparam logic [1:0] QUAL_SEL_10     = 2'h1;
  localparam logic [1:0] QUAL_SEL_30     = 2'h2;
  localparam logic [3:0] CTRL_RESET      = 4'h8;

  // Console codes
  localparam logic [15:0] MENU_LINE_COND  = 16'h0004;
  localparam logic [15:0] PASSWORD_FACT   = 16'h1111;
  localparam logic [7:0]  PNUM_UPPER_LIM  = 8'h28;
  localparam logic [7:0]  PNUM_LOWER_LIM  = 8'h29;
  localparam logic [7:0]  PNUM_UP_ENTRY   = 8'h2D;
  localparam logic [7:0]  PNUM_DN_ENTRY   = 8'h2E;
  localparam logic [7:0]  PNUM_UPPER_GAP  = 8'h30;
  localparam logic [7:0]  PNUM_LOWER_GAP  = 8'h31;

  // Setpoint defaults (volts)
  localparam logic [7:0] UPPER_LIM_BUCK_OFF  = 8'h82;
  localparam logic [7:0] UPPER_LIM_BUCK_ON   = 8'h96;
  localparam logic [7:0] LOWER_LIM_BOOST_OFF = 8'h64;
  localparam logic [7:0] LOWER_LIM_BOOST_ON  = 8'h5A;
  localparam logic [7:0] DN_ENTRY_DEFAULT    = 8'h82;
  localparam logic [7:0] UP_ENTRY_DEFAULT    = 8'h66;
  localparam logic [7:0] GAP_DEFAULT         = 8'h05;

  // Setpoint ranges (volts)
  localparam logic [7:0] UPPER_LIM_MIN = 8'h78;
  localparam logic [7:0] UPPER_LIM_MAX = 8'h96;
  localparam logic [7:0] DN_ENTRY_MIN  = 8'h78;
  localparam logic [7:0] DN_ENTRY_MAX  = 8'h90;
  localparam logic [7:0] UP_ENTRY_MIN  = 8'h60;
  localparam logic [7:0] UP_ENTRY_MAX  = 8'h78;
  localparam logic [7:0] LOWER_LIM_MIN = 8'h5A;
  localparam logic [7:0] LOWER_LIM_MAX = 8'h78;
  localparam logic [7:0] GAP_MIN       = 8'h03;
  localparam logic [7:0] GAP_MAX       = 8'h07;

  typedef enum logic [1:0] {
    MODE_LINE    = 2'b00,
    MODE_BUCK    = 2'b01,
    MODE_BOOST   = 2'b10,
    MODE_BATTERY = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    SCR_MAIN     = 2'b00,
    SCR_PASSWORD = 2'b01,
    SCR_PARAM    = 2'b10,
    SCR_LINECOND = 2'b11
  } screen_e;

endpackage

/* src/levels_if.sv */
// Carries stored setpoints to the level calculator and effective levels back.
// Assumes a single clock domain; purely combinational signals.
`timescale 1ns/1ns
interface levels_if;
  logic [7:0] upper_lim;
  logic [7:0] lower_lim;
  logic [7:0] dn_entry;
  logic [7:0] up_entry;
  logic [7:0] upper_band_gap;
  logic [7:0] lower_band_gap;
  logic       upper_set;
  logic       lower_set;
  logic       buck_en;
  logic       boost_en;
  logic [7:0] upper_transfer_limit;
  logic [7:0] upper_return_level;
  logic [7:0] lower_transfer_limit;
  logic [7:0] lower_return_level;
  logic [7:0] step_down_entry_level;
  logic [7:0] step_down_exit_level;
  logic [7:0] step_up_entry_level;
  logic [7:0] step_up_exit_level;

  modport ctl (output upper_lim, lower_lim, dn_entry, up_entry, upper_band_gap, lower_band_gap,
               upper_set, lower_set, buck_en, boost_en,
               input upper_transfer_limit, upper_return_level, lower_transfer_limit, lower_return_level,
               step_down_entry_level, step_down_exit_level, step_up_entry_level, step_up_exit_level);
  modport calc (input upper_lim, lower_lim, dn_entry, up_entry, upper_band_gap, lower_band_gap,
                upper_set, lower_set, buck_en, boost_en,
                output upper_transfer_limit, upper_return_level, lower_transfer_limit, lower_return_level,
                step_down_entry_level, step_down_exit_level, step_up_entry_level, step_up_exit_level);
endinterface

/* src/level_calc.sv */
// Derives the effective transfer, return, entry and exit levels.
// Assumes stored setpoints already lie within their ranges.
`timescale 1ns/1ns
module level_calc
  import line_xfer_pkg::*;
(
  // Setpoints in, levels out
  levels_if.calc lv
);

  // Saturating add and subtract so a level never wraps
  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hFF : s[7:0];
  endfunction

  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? (a - b) : 8'h00;
  endfunction

  // Untouched limits follow the enable state defaults
  assign lv.upper_transfer_limit = lv.upper_set ? lv.upper_lim :
                                   (lv.buck_en ? UPPER_LIM_BUCK_ON : UPPER_LIM_BUCK_OFF);
  assign lv.lower_transfer_limit = lv.lower_set ? lv.lower_lim :
                                   (lv.boost_en ? LOWER_LIM_BOOST_ON : LOWER_LIM_BOOST_OFF);

  // Return levels sit one gap inside the limits
  assign lv.upper_return_level = sat_sub(lv.upper_transfer_limit, lv.upper_band_gap);
  assign lv.lower_return_level = sat_add(lv.lower_transfer_limit, lv.lower_band_gap);

  // Exit levels recomputed whenever a setpoint moves
  assign lv.step_down_entry_level = lv.dn_entry;
  assign lv.step_down_exit_level  = sat_sub(lv.dn_entry, lv.upper_band_gap);
  assign lv.step_up_entry_level   = lv.up_entry;
  assign lv.step_up_exit_level    = sat_add(lv.up_entry, lv.lower_band_gap);

endmodule

/* src/sec_tick.sv */
// Divider giving a one-cycle pulse once per second while enabled.
// Assumes the count restarts whenever the enable drops.
`timescale 1ns/1ns
module sec_tick #(
  parameter int unsigned TICK_CYCLES = 100_000_000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Control and pulse
  input  wire logic run,
  output logic      tick
);

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  wire           wrap = (cnt_reg == LAST);

  // Restart on idle so each qualify period starts clean
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= run & wrap;
      cnt_reg <= (!run || wrap) ? '0 : cnt_reg + 1'b1;
    end
  end

endmodule

/* src/line_xfer_ctrl.sv */
// Line mode transfer controller with Wishbone registers and operator console.
// Assumes vin is a whole-volt measurement synchronous to core_clk.
// Assumes the bus master holds cyc and stb until it sees ack.
// Assumes setpoints change only through console key entries.
// Function
// - above upper transfer limit in line or step-down, go to battery.
// - step-down enabled and above entry level in line, enter step-down.
// - after high transfer, return to line below upper return level.
// - in step-down, return to line below step-down exit level.
// - step-up enabled and below entry level in line, enter step-up.
// - in step-up, return to line above step-up exit level.
// - below lower transfer limit in line or step-up, go to battery.
// - after low transfer, return to line above lower return level.
// - upper return level sits one programmable upper gap below limit.
// - lower return level sits one programmable lower gap above limit.
// - menu item 4 opens setpoint editing only after password 1111.
// - wrong password flags an error and allows a retry, no access.
// - accept setpoint only within range, then show line conditioning screen.
// - delay battery to line by 3, 10 or 30 qualified seconds.
`timescale 1ns/1ns
module line_xfer_ctrl
  import line_xfer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CYCLES_PER_SEC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Line measurement
  input  wire logic [7:0]  vin,
  // Power stage
  output logic [1:0]       mode_sel
);

  // State
  // Enum state and plain flags; mode resets to line, screen to main, flags to zero
  mode_e       mode_reg, mode_next;
  screen_e     screen_reg, screen_next;
  logic        bat_high_reg, bat_high_next;
  logic [4:0]  qual_sec_reg, qual_sec_next;
  logic [3:0]  ctrl_reg;
  logic [7:0]  upper_lim_reg, lower_lim_reg, dn_entry_reg, up_entry_reg;
  logic [7:0]  upper_gap_reg, lower_gap_reg;
  logic        upper_set_reg, lower_set_reg;
  logic        pw_err_reg, range_err_reg;
  logic        sec_pulse;

  // Setpoints out, effective levels back
  levels_if lv();

  // Range check used for every editable setpoint
  // Bounds inclusive; derived levels have no entry
  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Bus decode; a request counts once, on the edge before ack,
  // so a master holding through ack never writes twice
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_req    = bus_req & wb_we_i;
  wire        wr_ctrl   = wr_req & (wb_adr_i == OFS_CTRL) & wb_sel_i[0];
  wire        key_enter = wr_req & (wb_adr_i == OFS_KEY) & (&wb_sel_i[1:0]);
  wire [15:0] key_val   = wb_dat_i[15:0];
  wire [7:0]  pnum      = key_val[15:8];
  wire [7:0]  pval      = key_val[7:0];

  // Control fields; select 3 means the longest period
  wire        buck_en   = ctrl_reg[CTRL_BUCK_BIT];
  wire        boost_en  = ctrl_reg[CTRL_BOOST_BIT];
  wire [1:0]  qual_sel  = ctrl_reg[CTRL_QUAL_LSB +: 2];

  // Parameter number decode and range test
  // Derived level numbers match no select, so they fail
  wire sel_upper  = (pnum == PNUM_UPPER_LIM);
  wire sel_lower  = (pnum == PNUM_LOWER_LIM);
  wire sel_dn     = (pnum == PNUM_DN_ENTRY);
  wire sel_up     = (pnum == PNUM_UP_ENTRY);
  wire sel_ugap   = (pnum == PNUM_UPPER_GAP);
  wire sel_lgap   = (pnum == PNUM_LOWER_GAP);
  wire pval_ok    = (sel_upper & in_range(pval, UPPER_LIM_MIN, UPPER_LIM_MAX)) |
                    (sel_lower & in_range(pval, LOWER_LIM_MIN, LOWER_LIM_MAX)) |
                    (sel_dn    & in_range(pval, DN_ENTRY_MIN, DN_ENTRY_MAX))   |
                    (sel_up    & in_range(pval, UP_ENTRY_MIN, UP_ENTRY_MAX))   |
                    (sel_ugap  & in_range(pval, GAP_MIN, GAP_MAX))             |
                    (sel_lgap  & in_range(pval, GAP_MIN, GAP_MAX));
  // Entries count only on their own screen
  wire in_param   = (screen_reg == SCR_PARAM);
  wire accept     = key_enter & in_param & pval_ok;
  wire reject     = key_enter & in_param & ~pval_ok;
  wire pw_try     = key_enter & (screen_reg == SCR_PASSWORD);
  wire pw_good    = pw_try & (key_val == PASSWORD_FACT);

  // Setpoints to the level calculator
  // Enables pick the defaults of limits never edited
  assign lv.upper_lim      = upper_lim_reg;
  assign lv.lower_lim      = lower_lim_reg;
  assign lv.dn_entry       = dn_entry_reg;
  assign lv.up_entry       = up_entry_reg;
  assign lv.upper_band_gap = upper_gap_reg;
  assign lv.lower_band_gap = lower_gap_reg;
  assign lv.upper_set      = upper_set_reg;
  assign lv.lower_set      = lower_set_reg;
  assign lv.buck_en        = buck_en;
  assign lv.boost_en       = boost_en;

  // Effective levels, purely combinational
  level_calc u_calc (
    .lv (lv.calc)
  );

  // Voltage comparisons against effective levels
  // Strict compares: a line sitting on a level moves nothing
  // A disabled step mode forces its leave term true
  wire over_upper  = vin > lv.upper_transfer_limit;
  wire under_lower = vin < lv.lower_transfer_limit;
  wire ok_high     = vin < lv.upper_return_level;
  wire ok_low      = vin > lv.lower_return_level;
  wire dn_enter    = buck_en & (vin > lv.step_down_entry_level);
  wire dn_leave    = ~buck_en | (vin < lv.step_down_exit_level);
  wire up_enter    = boost_en & (vin < lv.step_up_entry_level);
  wire up_leave    = ~boost_en | (vin > lv.step_up_exit_level);
  wire qualified   = (mode_reg == MODE_BATTERY) & (bat_high_reg ? ok_high : ok_low);

  // Qualify period selected from control
  // Counted in whole seconds of divider pulses
  wire [4:0] qual_target = (qual_sel == QUAL_SEL_3)  ? QUAL_3_SEC  :
                           (qual_sel == QUAL_SEL_10) ? QUAL_10_SEC : QUAL_30_SEC;

  // Runs only while qualified, so any dip restarts the second
  sec_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (qualified),
    .tick     (sec_pulse)
  );

  // Mode transitions; battery checks take priority over step modes
  // Only the battery return is delayed; other moves land one edge
  // after the compare sees vin
  always_comb begin
    mode_next     = mode_reg;
    bat_high_next = bat_high_reg;
    qual_sec_next = qual_sec_reg;
    unique case (mode_reg)
      // Battery checks first, then step-down before step-up
      MODE_LINE: begin
        if (over_upper) begin
          mode_next     = MODE_BATTERY;
          bat_high_next = 1'b1;
        end else if (under_lower) begin
          mode_next     = MODE_BATTERY;
          bat_high_next = 1'b0;
        end else if (dn_enter) begin
          mode_next     = MODE_BUCK;
        end else if (up_enter) begin
          mode_next     = MODE_BOOST;
        end
      end
      MODE_BUCK: begin
        if (over_upper) begin
          mode_next     = MODE_BATTERY;
          bat_high_next = 1'b1;
        end else if (dn_leave) begin
          mode_next     = MODE_LINE;
        end
      end
      MODE_BOOST: begin
        if (under_lower) begin
          mode_next     = MODE_BATTERY;
          bat_high_next = 1'b0;
        end else if (up_leave) begin
          mode_next     = MODE_LINE;
        end
      end
      // Whole qualified seconds only; a dip clears the count
      MODE_BATTERY: begin
        if (!qualified) begin
          qual_sec_next = 5'h00;
        end else if (sec_pulse) begin
          if (qual_sec_reg + 5'h01 >= qual_target) begin
            mode_next     = MODE_LINE;
            qual_sec_next = 5'h00;
          end else begin
            qual_sec_next = qual_sec_reg + 5'h01;
          end
        end
      end
    endcase
  end

  // Console screen flow
  // Wrong main menu entries are ignored, not flagged
  always_comb begin
    screen_next = screen_reg;
    if (key_enter) begin
      unique case (screen_reg)
        SCR_MAIN:     if (key_val == MENU_LINE_COND) screen_next = SCR_PASSWORD;
        SCR_PASSWORD: if (pw_good) screen_next = SCR_PARAM;
        SCR_PARAM:    if (pval_ok) screen_next = SCR_LINECOND;
        SCR_LINECOND: screen_next = SCR_MAIN;
      endcase
    end
  end

  // Mode, screen and timer registers
  // mode_sel follows mode_next so the stage gets a flop output
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg     <= MODE_LINE;
      bat_high_reg <= 1'b0;
      qual_sec_reg <= 5'h00;
      screen_reg   <= SCR_MAIN;
      mode_sel     <= MODE_LINE;
    end else begin
      mode_reg     <= mode_next;
      bat_high_reg <= bat_high_next;
      qual_sec_reg <= qual_sec_next;
      screen_reg   <= screen_next;
      mode_sel     <= mode_next;
    end
  end

  // Error flags stand until the next attempt on the same screen
  // Only entries on the owning screen write each flag
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pw_err_reg    <= 1'b0;
      range_err_reg <= 1'b0;
    end else begin
      if (pw_try) pw_err_reg <= ~pw_good;
      if (key_enter && in_param) range_err_reg <= reject;
    end
  end

  // Control and setpoint storage; a limit once edited stops tracking its default
  // Control writes need byte lane 0; other lanes are ignored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg      <= CTRL_RESET;
      upper_lim_reg <= UPPER_LIM_BUCK_OFF;
      lower_lim_reg <= LOWER_LIM_BOOST_OFF;
      dn_entry_reg  <= DN_ENTRY_DEFAULT;
      up_entry_reg  <= UP_ENTRY_DEFAULT;
      upper_gap_reg <= GAP_DEFAULT;
      lower_gap_reg <= GAP_DEFAULT;
      upper_set_reg <= 1'b0;
      lower_set_reg <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= wb_dat_i[3:0];
      if (accept && sel_upper) begin
        upper_lim_reg <= pval;
        upper_set_reg <= 1'b1;
      end
      if (accept && sel_lower) begin
        lower_lim_reg <= pval;
        lower_set_reg <= 1'b1;
      end
      if (accept && sel_dn)   dn_entry_reg  <= pval;
      if (accept && sel_up)   up_entry_reg  <= pval;
      if (accept && sel_ugap) upper_gap_reg <= pval;
      if (accept && sel_lgap) lower_gap_reg <= pval;
    end
  end

  // Read mux; unmapped addresses read as zero but still acknowledge
  // Level words: limit, return, entry, exit, high byte first
  wire [31:0] status_word = {24'h000000, qualified, range_err_reg, pw_err_reg, bat_high_reg,
                             screen_reg, mode_reg};
  wire [31:0] rd_word =
    (wb_adr_i == OFS_CTRL)   ? {28'h0000000, ctrl_reg} :
    (wb_adr_i == OFS_KEY)    ? 32'h00000000 :
    (wb_adr_i == OFS_STATUS) ? status_word :
    (wb_adr_i == OFS_UPPER)  ? {lv.upper_transfer_limit, lv.upper_return_level,
                                lv.step_down_entry_level, lv.step_down_exit_level} :
    (wb_adr_i == OFS_LOWER)  ? {lv.lower_transfer_limit, lv.lower_return_level,
                                lv.step_up_entry_level, lv.step_up_exit_level} :
    (wb_adr_i == OFS_GAPS)   ? {16'h0000, upper_gap_reg, lower_gap_reg} :
    (wb_adr_i == OFS_VIN)    ? {24'h000000, vin} : 32'h00000000;

  // Single-cycle acknowledge; ack drops the cycle after it is given
  // Read data holds after ack until the next read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) wb_dat_o <= rd_word;
    end
  end

endmodule

/* sim/line_source.sv */
// Model of the mains feed: measured volts slewing to a target.
// Assumes the bench sets the target right after a clock edge.
`timescale 1ns/1ns
module line_source (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Target and measured line
  input  wire logic [7:0] target,
  output logic      [7:0] vin
);
  // One volt a cycle, so every threshold is crossed, never jumped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vin <= 8'h78;
    end else if (vin < target) begin
      vin <= vin + 8'h01;
    end else if (vin > target) begin
      vin <= vin - 8'h01;
    end
  end
endmodule

/* sim/line_xfer_ctrl_asserts.sv */
// Checker on the ports of the line mode transfer block.
// Assumes one clock domain and the asynchronous low reset.
`timescale 1ns/1ns
module line_xfer_ctrl_asserts
  import line_xfer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CYCLES_PER_SEC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Bus handshake
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_ack_o,
  // Line and stage
  input  wire logic [7:0] vin,
  input  wire logic [1:0] mode_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Bus answers exactly one cycle after a taken request
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one cycle pulse");
  // Limits never exceed their widest settings, so these always trip
  high_from_line_a: assert property (
    mode_sel == MODE_LINE && vin > 8'h96 |=> mode_sel == MODE_BATTERY) else $error("no high transfer");
  high_from_buck_a: assert property (
    mode_sel == MODE_BUCK && vin > 8'h96 |=> mode_sel == MODE_BATTERY) else $error("no high transfer");
  low_from_line_a: assert property (
    mode_sel == MODE_LINE && vin < 8'h5A |=> mode_sel == MODE_BATTERY) else $error("no low transfer");
  // Step modes live only inside their widest bands
  buck_band_a: assert property (
    mode_sel == MODE_BUCK |-> $past(vin) > 8'h70) else $error("step-down out of band");
  boost_band_a: assert property (
    mode_sel == MODE_BOOST |-> $past(vin) < 8'h80) else $error("step-up out of band");
  step_entry_a: assert property (
    mode_sel inside {MODE_BUCK, MODE_BOOST} && $past(mode_sel) != mode_sel |-> $past(mode_sel) == MODE_LINE)
    else $error("step mode not entered from line");
  // Battery exits only to line, and never at once
  bat_exit_a: assert property (
    $past(mode_sel) == MODE_BATTERY |-> mode_sel inside {MODE_LINE, MODE_BATTERY}) else $error("bad exit");
  bat_hold_a: assert property (
    mode_sel == MODE_BATTERY && $past(mode_sel) != MODE_BATTERY |-> mode_sel == MODE_BATTERY [*3])
    else $error("battery left too soon");

  // Main scenarios reached
  cover property (mode_sel == MODE_BUCK);
  cover property (mode_sel == MODE_BOOST);
  cover property ($past(mode_sel) == MODE_BATTERY && mode_sel == MODE_LINE);
endmodule

bind line_xfer_ctrl line_xfer_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
  .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .vin(vin), .mode_sel(mode_sel));

/* sim/line_xfer_ctrl_tb.sv */
// Self-checking bench for the line mode transfer block.
// Assumes the mains model and the checker are compiled alongside.
`timescale 1ns/1ns
module line_xfer_ctrl_tb;
  import line_xfer_pkg::*;
  localparam int TC = 10;
  logic        core_clk     = 1'b0;
  logic        resetn       = 1'b0;
  logic        cyc          = 1'b0;
  logic        stb          = 1'b0;
  logic        we           = 1'b0;
  logic [3:0]  sel          = 4'h0;
  logic [7:0]  adr          = 8'h00;
  logic [31:0] dat          = 32'h0;
  logic [7:0]  tgt          = 8'h78;
  logic [31:0] lfsr         = 32'hDAF914B0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic [1:0]  mode;
  logic [7:0]  vin;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          n;

  // Clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  line_xfer_ctrl #(.TICK_CYCLES(TC)) uut (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .vin(vin), .mode_sel(mode));
  line_source src (.core_clk(core_clk), .resetn(resetn), .target(tgt), .vin(vin));

  // Expected level words
  function automatic logic [31:0] up_w(input logic [7:0] l, input logic [7:0] g, input logic [7:0] e);
    return {l, l - g, e, e - g};
  endfunction
  function automatic logic [31:0] lo_w(input logic [7:0] l, input logic [7:0] g, input logic [7:0] e);
    return {l, l + g, e, e + g};
  endfunction
  function automatic int qual(input int s);
    return (s == 0 ? 3 : s == 1 ? 10 : 30) * TC;
  endfunction
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input logic [1:0] m);
    chk({30'h0, mode}, {30'h0, m});
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      final_report();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Console entry, then screen and error flags from status
  task automatic con(input logic [15:0] v, input logic [31:0] e);
    wb(1'b1, OFS_KEY, {16'h0, v});
    rd(8'h08, e);
    chk(q & 32'h6C, e);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    n = 0;
    while (mode !== m && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      n_mismatch++;
      final_report();
    end
    chk_mode(m);
  endtask
  // Line parked near a threshold long enough to cross it if wrong
  task automatic hold(input logic [7:0] v, input logic [1:0] m);
    tgt <= v;
    repeat (60) @(posedge core_clk);
    chk_mode(m);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(OFS_CTRL, {28'h0, CTRL_RESET});
    rd(OFS_GAPS, {16'h0, GAP_DEFAULT, GAP_DEFAULT});
    rd(OFS_UPPER, up_w(UPPER_LIM_BUCK_OFF, GAP_DEFAULT, DN_ENTRY_DEFAULT));
    rd(OFS_LOWER, lo_w(LOWER_LIM_BOOST_OFF, GAP_DEFAULT, UP_ENTRY_DEFAULT));
    rd(8'h40, 32'h0);
    $display("test reset done");
    // High excursion under each qualify period
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, OFS_CTRL, 32'(s << 2));
      tgt <= 8'h97;
      wait_mode(MODE_BATTERY);
      hold(8'h7D, MODE_BATTERY);
      tgt <= 8'h7C;
      wait_mode(MODE_LINE);
      chk(32'(n >= qual(s) && n <= qual(s) + 8), 32'h1);
    end
    tgt <= 8'h59;
    wait_mode(MODE_BATTERY);
    hold(8'h69, MODE_BATTERY);
    tgt <= 8'h6A;
    wait_mode(MODE_LINE);
    $display("test battery done");
    wb(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_UPPER, up_w(UPPER_LIM_BUCK_ON, GAP_DEFAULT, DN_ENTRY_DEFAULT));
    tgt <= 8'h83;
    wait_mode(MODE_BUCK);
    tgt <= 8'h97;
    wait_mode(MODE_BATTERY);
    tgt <= 8'h83;
    wait_mode(MODE_BUCK);
    hold(8'h7D, MODE_BUCK);
    tgt <= 8'h7C;
    wait_mode(MODE_LINE);
    $display("test step-down done");
    wb(1'b1, OFS_CTRL, 32'h2);
    rd(OFS_LOWER, lo_w(LOWER_LIM_BOOST_ON, GAP_DEFAULT, UP_ENTRY_DEFAULT));
    tgt <= 8'h65;
    wait_mode(MODE_BOOST);
    tgt <= 8'h59;
    wait_mode(MODE_BATTERY);
    tgt <= 8'h65;
    wait_mode(MODE_BOOST);
    hold(8'h6B, MODE_BOOST);
    tgt <= 8'h6C;
    wait_mode(MODE_LINE);
    tgt <= 8'h65;
    wait_mode(MODE_BOOST);
    wb(1'b1, OFS_CTRL, 32'h0);
    wait_mode(MODE_LINE);
    $display("test step-up done");
    // Random line inside the dead band must leave line mode alone
    repeat (16) begin
      lfsr = next_rand(lfsr);
      tgt <= 8'h6A + 8'(lfsr[7:0] % 8'h12);
      repeat (30) @(posedge core_clk);
      chk_mode(MODE_LINE);
      rd(OFS_VIN, {24'h0, tgt});
    end
    $display("test random done");
    lfsr = next_rand(lfsr);
    con(16'h0003, 32'h00);
    con(16'h0004, 32'h04);
    con(lfsr[15:0] == PASSWORD_FACT ? 16'h2222 : lfsr[15:0], 32'h24);
    con(PASSWORD_FACT, 32'h08);
    con(16'h2897, 32'h48);
    con(16'h3008, 32'h48);
    con(16'h3003, 32'h0C);
    rd(OFS_GAPS, {16'h0, 8'h03, GAP_DEFAULT});
    rd(OFS_UPPER, up_w(UPPER_LIM_BUCK_OFF, 8'h03, DN_ENTRY_DEFAULT));
    con(16'h0000, 32'h00);
    // Edited limits stay put and open the widest line band
    for (int i = 0; i < 2; i++) begin
      con(16'h0004, 32'h04);
      con(PASSWORD_FACT, 32'h08);
      con(i ? 16'h2F7D : 16'h2A7D, 32'h48);
      con(i ? 16'h295A : 16'h2896, 32'h0C);
      con(16'h0000, 32'h00);
    end
    rd(OFS_UPPER, up_w(8'h96, 8'h03, DN_ENTRY_DEFAULT));
    rd(OFS_LOWER, lo_w(8'h5A, GAP_DEFAULT, UP_ENTRY_DEFAULT));
    tgt <= 8'h97;
    wait_mode(MODE_BATTERY);
    tgt <= 8'h92;
    wait_mode(MODE_LINE);
    tgt <= 8'h59;
    wait_mode(MODE_BATTERY);
    $display("test console done");
    final_report();
  end
endmodule
